// *** clock_flags_pkg.sv ***
// Constants, register layout and reset values for the clock ready flag block
// Assumes an APB slave with 32-bit data on pclk, reset presetn
// Notes on behaviour
// (RL1) Monitor sees crystal stopped: set stuck flag
// (RL2) Write one to stuck clear resets flag
// (RL3) Stuck flag reads 0 normal, 1 stuck
// (RL4) Software keeps reserved bit 6 at reset
// (RL5) Aux RC flag bit 5 set when stable, enabled
// (RL6) Aux RC clear bit resets its flag
// (RL7) Ready flags read 1 once interrupt generated
// (RL8) PLL flag bit 4 set when locked, enabled
// (RL9) PLL clear bit resets PLL flag
// (RL10) HS crystal flag bit 3 set when stable, enabled
// (RL11) HS crystal clear bit resets its flag
// (RL12) Fast RC flag bit 2 set when stable, enabled
// (RL13) Fast RC clear bit resets its flag
// (RL14) LS crystal flag bit 1 set when stable, enabled
// (RL15) LS crystal clear bit resets its flag
// (RL16) Slow RC flag bit 0 set when stable, enabled
// (RL17) Flag writes ignored; zero clear changes nothing
// (RL18) Interrupt high while any flag with its mask bit set is set
package clock_flags_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] MASK_RESET = 8'hff;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int NUM_SOURCES = 6;
    localparam int FLAG_LSB = 0;
    localparam int STUCK_FLAG_BIT = 7;
    localparam int ENABLE_LSB = 8;
    localparam int CLEAR_LSB = 16;
    localparam int STUCK_CLEAR_BIT = 23;
    localparam int SYNC_STAGES = 3;
endpackage

// *** level_sync.sv ***
// Three-stage synchroniser with agreement filter for one level input
// Assumes the input is asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    import clock_flags_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] stage;
        logic out;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage = {state_reg.stage[SYNC_STAGES-2:0], async_in};
        // Only stages two and three vote; stage one feeds stage two alone
        if (state_reg.stage[1] == state_reg.stage[2]) begin
            state_next.out = state_reg.stage[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.out;
endmodule
`default_nettype wire

// *** clock_ready_interrupt_flags.sv ***
// APB register block holding oscillator ready flags and the crystal stuck flag
// Assumes ready and stuck status arrive asynchronously from the analog clock sources
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module clock_ready_interrupt_flags (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_internal_rc_stable,
    input wire logic low_speed_crystal_stable,
    input wire logic fast_internal_rc_stable,
    input wire logic high_speed_crystal_stable,
    input wire logic pll_locked,
    input wire logic aux_internal_rc_stable,
    input wire logic high_speed_crystal_stuck,
    output logic clock_irq
);
    import clock_flags_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NUM_SOURCES-1:0] ready_flag;
        logic [NUM_SOURCES-1:0] int_en;
        logic stuck_flag;
        logic [NUM_SOURCES-1:0] stable_prev;
        logic stuck_prev;
        logic [7:0] mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
    } regs_s;

    regs_s state_reg;
    regs_s state_next;

    logic [NUM_SOURCES-1:0] stable_raw;
    logic [NUM_SOURCES-1:0] stable_sync;
    logic stuck_sync;
    logic access;
    logic wr_ctrl;
    logic wr_mask;
    logic hit_ctrl;
    logic hit_mask;
    logic [7:0] status;

    assign stable_raw = {aux_internal_rc_stable, pll_locked, high_speed_crystal_stable,
                         fast_internal_rc_stable, low_speed_crystal_stable, slow_internal_rc_stable};

    // ****************************************
    // Input synchronisers
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_sync
            level_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .async_in(stable_raw[gi]),
                .sync_out(stable_sync[gi])
            );
        end
    endgenerate

    level_sync u_stuck_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(high_speed_crystal_stuck),
        .sync_out(stuck_sync)
    );

    // ****************************************
    // Bus decode
    // ****************************************
    // One wait state: ready rises in the cycle after the first access cycle and falls after it
    assign access = psel && penable && !state_reg.ready;
    assign hit_ctrl = (paddr[7:0] == CTRL_OFFSET) && (paddr[31:8] == 24'h000000);
    assign hit_mask = (paddr[7:0] == MASK_OFFSET) && (paddr[31:8] == 24'h000000);
    assign wr_ctrl = access && pwrite && hit_ctrl;
    assign wr_mask = access && pwrite && hit_mask;

    always_comb begin
        state_next = state_reg;
        state_next.stable_prev = stable_sync;
        state_next.stuck_prev = stuck_sync;
        state_next.ready = access;
        state_next.err = access && !hit_ctrl && !hit_mask;
        state_next.rdata = 32'h0000_0000;

        // Flags sample as events on the stable edge so a held ready level
        // does not refire after software clears it
        for (int i = 0; i < NUM_SOURCES; i++) begin
            // Clear first so a same-cycle set wins
            if (wr_ctrl && pwdata[CLEAR_LSB + i]) begin
                state_next.ready_flag[i] = 1'b0; // see (RL6) (RL9) (RL11) (RL13) (RL15) (RL17)
            end
            if (stable_sync[i] && !state_reg.stable_prev[i] && state_reg.int_en[i]) begin
                state_next.ready_flag[i] = 1'b1; // see (RL5) (RL7) (RL8) (RL10) (RL12) (RL14) (RL16)
            end
        end
        if (wr_ctrl && pwdata[STUCK_CLEAR_BIT]) begin
            state_next.stuck_flag = 1'b0; // see (RL2)
        end
        if (stuck_sync && !state_reg.stuck_prev) begin
            state_next.stuck_flag = 1'b1; // see (RL1) (RL3)
        end
        if (wr_ctrl) begin
            state_next.int_en = pwdata[ENABLE_LSB +: NUM_SOURCES];
        end
        if (wr_mask) begin
            state_next.mask = pwdata[7:0];
        end

        if (access && !pwrite && hit_ctrl) begin
            state_next.rdata[STUCK_FLAG_BIT] = state_reg.stuck_flag;
            state_next.rdata[FLAG_LSB +: NUM_SOURCES] = state_reg.ready_flag;
            state_next.rdata[ENABLE_LSB +: NUM_SOURCES] = state_reg.int_en;
        end else if (access && !pwrite && hit_mask) begin
            state_next.rdata[7:0] = state_reg.mask;
        end

        // Built from the next state so the request follows a flag on the same edge
        status = {state_next.stuck_flag, 1'b0, state_next.ready_flag};
        state_next.irq = |(status & state_next.mask); // see (RL18)
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.int_en <= CTRL_RESET[ENABLE_LSB +: NUM_SOURCES];
            state_reg.mask <= MASK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
    assign clock_irq = state_reg.irq;
endmodule
`default_nettype wire

// *** flags_chk_assertions.sv ***
// Checker for the clock ready flag block, bound to its top module
// Assumes the control word at 0x08 and the mask at 0x0c
`timescale 1ns/1ps
`default_nettype none
module flags_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clock_irq,
    input wire logic slow_internal_rc_stable,
    input wire logic low_speed_crystal_stable,
    input wire logic fast_internal_rc_stable,
    input wire logic high_speed_crystal_stable,
    input wire logic pll_locked,
    input wire logic aux_internal_rc_stable,
    input wire logic high_speed_crystal_stuck,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata
);
    // ****************************************
    // Quiet tracker: no source seen since reset
    // ****************************************
    logic quiet_reg;
    wire any_in = slow_internal_rc_stable | low_speed_crystal_stable | fast_internal_rc_stable |
        high_speed_crystal_stable | pll_locked | aux_internal_rc_stable | high_speed_crystal_stuck;
    wire rd_ctrl = pready && !pwrite && paddr == 32'h8;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_reg <= 1'b1;
        else if (any_in) quiet_reg <= 1'b0;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    answer_next_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    decode_err_a: assert property (pready |-> pslverr == !(paddr == 32'h8 || paddr == 32'hc))
        else $error("bad decode");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error read");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("data while idle");
    rsvd_zero_a: assert property (rd_ctrl |-> prdata[31:16] == 16'h0 && !prdata[6])
        else $error("reserved or clear bits read nonzero");
    quiet_flag_a: assert property (quiet_reg && rd_ctrl |-> prdata[7:0] == 8'h0)
        else $error("flag without source");
    quiet_irq_a: assert property (quiet_reg |-> !clock_irq) else $error("irq without source");
    mask_off_a: assert property (pready && pwrite && paddr == 32'hc && pwdata[7:0] == 8'h0 |-> ##2 !clock_irq)
        else $error("irq with mask off");
    cover property ($rose(clock_irq));
    cover property (pslverr);
    cover property (rd_ctrl && prdata[7]);
endmodule
bind clock_ready_interrupt_flags flags_chk u_flags_chk (.*);
`default_nettype wire

// *** test_clock_ready_interrupt_flags.sv ***
// Self-checking bench for the clock ready flag block
// Assumes the block, its package and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_clock_ready_interrupt_flags;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stuck = 0, pready, pslverr, clock_irq, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [5:0] stab = 0, en;
    int mismatches = 0, n_tests = 0, seed = 37;
    clock_ready_interrupt_flags u_clock_ready_interrupt_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_internal_rc_stable(stab[0]), .low_speed_crystal_stable(stab[1]),
        .fast_internal_rc_stable(stab[2]), .high_speed_crystal_stable(stab[3]), .pll_locked(stab[4]),
        .aux_internal_rc_stable(stab[5]), .high_speed_crystal_stuck(stuck), .clock_irq(clock_irq));
    initial forever #12.5 pclk = ~pclk;
    function automatic logic [31:0] exp_ctrl(logic [5:0] e, s);
        return {18'h0, e, 2'h0, e & s};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask
    // Holds the request until pready is sampled; a dead slave is left to the watchdog
    // One idle edge after release so the next setup never reassigns psel in the same step
    task automatic apb(input logic wr, input logic [31:0] a, d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        summarize();
    end
    initial begin
        tick(2);
        presetn <= 1;
        tick(1);
        apb(0, 32'h8, 0);
        chk("ctrl reset", rd, 0);
        apb(0, 32'hc, 0);
        chk("mask reset", rd, 32'hff);
        apb(1, 32'h10, 32'hffff_ffff);
        apb(0, 32'h10, 0);
        chk("unmapped", {rd[30:0], err}, 1);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            apb(1, 32'h8, 32'h100 << i);
            stab <= 6'h1 << i;
            tick(8);
            apb(0, 32'h8, 0);
            chk("flag set", rd, 32'h101 << i);
            chk("irq on", clock_irq, 1);
            apb(1, 32'h8, (32'h100 << i) | 32'hbf);
            apb(0, 32'h8, 0);
            chk("flag kept", rd, 32'h101 << i);
            apb(1, 32'h8, 32'h10100 << i);
            apb(0, 32'h8, 0);
            chk("flag clear", rd, 32'h100 << i);
            chk("irq off", clock_irq, 0);
            stab <= 0;
            tick(8);
        end
        $display("source test done");
        stuck <= 1;
        tick(8);
        apb(0, 32'h8, 0);
        chk("stuck set", rd, 32'h2080);
        chk("stuck irq", clock_irq, 1);
        apb(1, 32'hc, 0);
        tick(2);
        chk("masked irq", clock_irq, 0);
        apb(1, 32'hc, 32'hff);
        apb(1, 32'h80_0000, 0);
        apb(1, 32'h8, 32'h80_0000);
        apb(0, 32'h8, 0);
        chk("stuck clear", rd, 0);
        stuck <= 0;
        $display("stuck test done");
        repeat (6) begin
            en = 6'($random(seed));
            apb(1, 32'h8, {18'h0, en, 8'h0});
            stab <= 6'($random(seed));
            tick(8);
            apb(0, 32'h8, 0);
            chk("random flags", rd, exp_ctrl(en, stab));
            apb(1, 32'h8, 32'h3f_0000);
            stab <= 0;
            tick(8);
        end
        $display("random test done");
        summarize();
    end
endmodule
`default_nettype wire
